// File: dcc_pkg.sv
// Summary of operation
// - source bit 0: channel read gives input data
// - source bit 1: channel read gives latch
// - update bit acts like load pin edge
// - pin high: update bit loads the written channels' latches
// - only channels written since last update reload
// - update bit clears itself when done
// - pin low: update bit write ignored
// - reset bit resets device like hardware reset
// - reset bit clears itself after reset
// - group a power-down covers channels 0, 1
// - group b power-down covers channels 2, 3
// - reserved bit ignores writes, reads zero
// - pin 1 bit: 0 drives low, 1 releases
// - pin 1 bit reads sampled pin level
// - pin 0 bit: 0 drives low, 1 releases
// - pin 0 bit reads sampled pin level
// - command register at 0000, resets 033Ch
package dcc_pkg;

   localparam int ADDR_W = 8;
   localparam int NUM_CHAN = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] CHAN_OFS = 8'h10;
   localparam logic [7:0] CHAN_MASK = 8'hF3;

   ////////////////////////////////////////////////////////////////////////////
   // command register fields
   localparam logic [15:0] CMD_RESET = 16'h033C;
   localparam logic [7:0] CMD_LOW_MASK = 8'hBC;
   localparam int BIT_SRC = 15;
   localparam int BIT_UPD = 14;
   localparam int BIT_SRST = 13;
   localparam int BIT_PDA = 12;
   localparam int BIT_PDB = 11;
   localparam int BIT_GP1 = 9;
   localparam int BIT_GP0 = 8;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int SRST_TIME_NS = 20;
   localparam logic [2:0] SRST_CYCLES = 3'((SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } dcc_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dcc_apb_rsp_t;

   typedef struct packed {
      logic src_sel;
      logic upd_busy;
      logic [2:0] srst_cnt;
      logic pd_a;
      logic pd_b;
      logic [1:0] gp_ctl;
      logic [7:0] low_store;
      logic [NUM_CHAN-1:0][15:0] indata;
      logic [NUM_CHAN-1:0][15:0] latch;
      logic [NUM_CHAN-1:0] dirty;
      logic [1:0] gp_meta;
      logic [1:0] gp_sync;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dcc_state_t;

   localparam dcc_state_t STATE_RESET = '{
      src_sel: CMD_RESET[BIT_SRC],
      upd_busy: 1'b0,
      srst_cnt: 3'h0,
      pd_a: CMD_RESET[BIT_PDA],
      pd_b: CMD_RESET[BIT_PDB],
      gp_ctl: CMD_RESET[BIT_GP1:BIT_GP0],
      low_store: CMD_RESET[7:0],
      indata: '0,
      latch: '0,
      dirty: '0,
      gp_meta: 2'h3,
      gp_sync: 2'h3,
      pin_meta: 1'b1,
      pin_sync: 1'b1,
      pin_prev: 1'b1,
      pready: 1'b0,
      pslverr: 1'b0,
      prdata: 32'h0000_0000
   };

endpackage : dcc_pkg

// File: dcc_command_control.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dcc_command_control (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire dcc_pkg::dcc_apb_req_t apb_req,
   output dcc_pkg::dcc_apb_rsp_t apb_rsp,
   input wire logic load_latch_pin_n,
   input wire logic [1:0] gp_pin_i,
   output logic [1:0] gp_pin_o,
   output logic [1:0] gp_pin_oe,
   output logic power_down_group_a,
   output logic power_down_group_b,
   output logic [dcc_pkg::NUM_CHAN-1:0][15:0] dac_latch
);
   import dcc_pkg::*;

   dcc_state_t s_ff;
   dcc_state_t nxt_s;

   ////////////////////////////////////////////////////////////////////////////
   // address decode: [2] channel hit, [1:0] channel index
   function automatic logic [2:0] chan_decode(input logic [ADDR_W-1:0] addr);
      logic [2:0] r;
      r = 3'h0;
      if ((addr & CHAN_MASK) == CHAN_OFS) begin
         r = {1'b1, addr[3:2]};
      end
      return r;
   endfunction : chan_decode

   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      logic [2:0] dec;
      dec = chan_decode(addr);
      return (addr == CMD_OFS) || dec[2];
   endfunction : is_mapped

   // device fields back to reset, leaving bus and sampling logic alone
   function automatic dcc_state_t dev_reset(input dcc_state_t st);
      dcc_state_t r;
      r = st;
      r.src_sel = STATE_RESET.src_sel;
      r.upd_busy = STATE_RESET.upd_busy;
      r.pd_a = STATE_RESET.pd_a;
      r.pd_b = STATE_RESET.pd_b;
      r.gp_ctl = STATE_RESET.gp_ctl;
      r.low_store = STATE_RESET.low_store;
      r.indata = STATE_RESET.indata;
      r.latch = STATE_RESET.latch;
      r.dirty = STATE_RESET.dirty;
      return r;
   endfunction : dev_reset

   ////////////////////////////////////////////////////////////////////////////
   // command register image as software reads it
   function automatic logic [15:0] cmd_image(
      input dcc_state_t st
   );
      logic [15:0] r;
      r = 16'h0000;
      r[BIT_SRC] = st.src_sel;
      r[BIT_UPD] = st.upd_busy;
      r[BIT_SRST] = (st.srst_cnt != 3'h0);
      r[BIT_PDA] = st.pd_a;
      r[BIT_PDB] = st.pd_b;
      r[BIT_GP1] = st.gp_sync[1];
      r[BIT_GP0] = st.gp_sync[0];
      r[7:0] = st.low_store;
      return r;
   endfunction : cmd_image

   // channel image, input data or output latch
   function automatic logic [15:0] chan_image(
      input dcc_state_t st,
      input logic [1:0] idx
   );
      logic [15:0] r;
      r = 16'h0000;
      if (st.src_sel) begin
         r = st.latch[idx];
      end else begin
         r = st.indata[idx];
      end
      return r;
   endfunction : chan_image

   // read value of the addressed register
   function automatic logic [15:0] read_value(
      input dcc_state_t st,
      input logic [ADDR_W-1:0] addr
   );
      logic [15:0] r;
      logic [2:0] dec;
      r = 16'h0000;
      dec = chan_decode(addr);
      if (addr == CMD_OFS) begin
         r = cmd_image(st);
      end else if (dec[2]) begin
         r = chan_image(st, dec[1:0]);
      end
      return r;
   endfunction : read_value

   ////////////////////////////////////////////////////////////////////////////
   // two-stage sampling of outside pins
   function automatic dcc_state_t sync_step(
      input dcc_state_t cur,
      input dcc_state_t acc,
      input logic [1:0] gp_in,
      input logic pin_in
   );
      dcc_state_t r;
      r = acc;
      r.gp_meta = gp_in;
      r.gp_sync = cur.gp_meta;
      r.pin_meta = pin_in;
      r.pin_sync = cur.pin_meta;
      r.pin_prev = cur.pin_sync;
      return r;
   endfunction : sync_step

   // falling edge of the synchronised load pin
   function automatic logic pin_fell(
      input dcc_state_t cur
   );
      return cur.pin_prev & ~cur.pin_sync;
   endfunction : pin_fell

   ////////////////////////////////////////////////////////////////////////////
   // bus answer: one wait cycle, then pready for one cycle
   function automatic dcc_state_t bus_step(
      input dcc_state_t cur,
      input dcc_state_t acc,
      input dcc_apb_req_t req
   );
      dcc_state_t r;
      r = acc;
      r.pready = 1'b0;
      r.pslverr = 1'b0;
      if (req.psel && req.penable && !cur.pready) begin
         r.pready = 1'b1;
         r.pslverr = !is_mapped(req.paddr);
         r.prdata = {16'h0000, read_value(cur, req.paddr)};
      end
      return r;
   endfunction : bus_step

   // a write acts in the cycle in which pready is shown
   function automatic logic write_done(
      input dcc_state_t cur,
      input dcc_apb_req_t req
   );
      return req.psel && req.penable && cur.pready && req.pwrite && !cur.pslverr;
   endfunction : write_done

   ////////////////////////////////////////////////////////////////////////////
   // software reset countdown
   function automatic dcc_state_t srst_step(
      input dcc_state_t cur,
      input dcc_state_t acc
   );
      dcc_state_t r;
      r = acc;
      if (cur.srst_cnt != 3'h0) begin
         r.srst_cnt = cur.srst_cnt - 3'h1;
      end
      return r;
   endfunction : srst_step

   ////////////////////////////////////////////////////////////////////////////
   // latch load from pin edge or update bit
   function automatic dcc_state_t update_step(
      input dcc_state_t cur,
      input dcc_state_t acc,
      input logic fall
   );
      dcc_state_t r;
      r = acc;
      if (fall || cur.upd_busy) begin
         for (int i = 0; i < NUM_CHAN; i++) begin
            if (cur.dirty[i]) begin
               r.latch[i] = cur.indata[i];
            end
         end
         r.dirty = '0;
         r.upd_busy = 1'b0;
      end
      return r;
   endfunction : update_step

   ////////////////////////////////////////////////////////////////////////////
   // command register write
   function automatic dcc_state_t cmd_write(
      input dcc_state_t cur,
      input dcc_state_t acc,
      input logic [15:0] wd
   );
      dcc_state_t r;
      r = acc;
      r.src_sel = wd[BIT_SRC];
      if (wd[BIT_UPD] && cur.pin_sync) begin
         r.upd_busy = 1'b1;
      end
      if (wd[BIT_SRST]) begin
         r.srst_cnt = SRST_CYCLES;
      end
      r.pd_a = wd[BIT_PDA];
      r.pd_b = wd[BIT_PDB];
      r.gp_ctl[1] = wd[BIT_GP1];
      r.gp_ctl[0] = wd[BIT_GP0];
      r.low_store = wd[7:0] & CMD_LOW_MASK;
      return r;
   endfunction : cmd_write

   // a write after the update marks the channel again
   function automatic dcc_state_t chan_write(
      input dcc_state_t acc,
      input logic [1:0] idx,
      input logic [15:0] wd
   );
      dcc_state_t r;
      r = acc;
      r.indata[idx] = wd;
      r.dirty[idx] = 1'b1;
      return r;
   endfunction : chan_write

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      logic wr_done;
      logic [2:0] dec;
      logic [15:0] wd;
      wr_done = 1'b0;
      dec = 3'h0;
      wd = 16'h0000;
      nxt_s = sync_step(s_ff, s_ff, gp_pin_i, load_latch_pin_n);
      nxt_s = bus_step(s_ff, nxt_s, apb_req);
      wr_done = write_done(s_ff, apb_req);
      nxt_s = srst_step(s_ff, nxt_s);
      nxt_s = update_step(s_ff, nxt_s, pin_fell(s_ff));

      if (wr_done && s_ff.srst_cnt == 3'h0) begin
         wd = apb_req.pwdata[15:0];
         dec = chan_decode(apb_req.paddr);
         if (apb_req.paddr == CMD_OFS) begin
            nxt_s = cmd_write(s_ff, nxt_s, wd);
         end else if (dec[2]) begin
            nxt_s = chan_write(nxt_s, dec[1:0], wd);
         end
      end

      if (nxt_s.srst_cnt != 3'h0) begin
         nxt_s = dev_reset(nxt_s);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= STATE_RESET;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign apb_rsp = '{pready: s_ff.pready, pslverr: s_ff.pslverr, prdata: s_ff.prdata};
   assign gp_pin_o = 2'h0;
   genvar gi;

   for (gi = 0; gi < 2; gi++) begin : g_gp
      assign gp_pin_oe[gi] = ~s_ff.gp_ctl[gi];
   end

   assign power_down_group_a = s_ff.pd_a;
   assign power_down_group_b = s_ff.pd_b;

   // one output latch per channel
   for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      assign dac_latch[gi] = s_ff.latch[gi];
   end

endmodule : dcc_command_control
`default_nettype wire

// File: dcc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_checker
   import dcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire dcc_pkg::dcc_apb_req_t apb_req,
   input wire dcc_pkg::dcc_apb_rsp_t apb_rsp,
   input wire logic load_latch_pin_n,
   input wire logic [1:0] gp_pin_o,
   input wire logic [1:0] gp_pin_oe,
   input wire logic power_down_group_a,
   input wire logic power_down_group_b,
   input wire logic [dcc_pkg::NUM_CHAN-1:0][15:0] dac_latch
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic cmd_w;
   assign cmd_w = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == CMD_OFS;
   sequence access_s;
      apb_req.psel && $rose(apb_req.penable);
   endsequence
   sequence pulse_s;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence
   chk_ready_wait: assert property (access_s |=> pulse_s)
      else $error("pready not one wait state pulse");
   chk_ready_cause: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
      else $error("pready without access");
   chk_err_data: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error response with data");
   chk_rsvd_zero: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == CMD_OFS
      |-> apb_rsp.prdata[10] == 1'b0 && apb_rsp.prdata[31:16] == 16'h0)
      else $error("reserved command bit not zero");
   chk_pin_low: assert property (gp_pin_o == 2'h0)
      else $error("general pin drives high");
   chk_ctl_hold: assert property (!cmd_w |=> $stable({gp_pin_oe, power_down_group_a, power_down_group_b}))
      else $error("control output moved without write");
   chk_soft_reset: assert property (cmd_w && apb_req.pwdata[13] |=> !power_down_group_a && !power_down_group_b
      && gp_pin_oe == 2'h0 && dac_latch == '0)
      else $error("soft reset left state");
   chk_latch_cause: assert property ($changed(dac_latch)
      |-> $past(cmd_w) || $past(cmd_w, 2) || !$past(load_latch_pin_n, 3))
      else $error("latch changed without load");
endmodule : dcc_checker
bind dcc_command_control dcc_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .load_latch_pin_n(load_latch_pin_n), .gp_pin_o(gp_pin_o), .gp_pin_oe(gp_pin_oe),
   .power_down_group_a(power_down_group_a), .power_down_group_b(power_down_group_b), .dac_latch(dac_latch));
`default_nettype wire

// File: dcc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcc_pin_model (
   input wire logic [1:0] pin_oe,
   input wire logic [1:0] pull_low,
   output logic [1:0] pin_level
);
   assign pin_level = ~(pin_oe | pull_low);
endmodule : dcc_pin_model
`default_nettype wire

// File: dac_command_control_upper_test.sv
`timescale 1ns/10ps
`default_nettype none
module dac_command_control_upper_test;
   import dcc_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic load_n = 1'b1;
   logic [1:0] pull_low = 2'h0;
   logic [1:0] lvl;
   logic [1:0] oe;
   dcc_apb_req_t req = '0;
   dcc_apb_rsp_t rsp;
   logic pd_a;
   logic pd_b;
   logic [NUM_CHAN-1:0][15:0] lat;
   logic [16:0] exp_q[$];
   logic [15:0] val[4];
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   int seed = 67874;
   always #2.5 clk_sys = ~clk_sys;
   dcc_command_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
      .load_latch_pin_n(load_n), .gp_pin_i(lvl), .gp_pin_o(), .gp_pin_oe(oe),
      .power_down_group_a(pd_a), .power_down_group_b(pd_b), .dac_latch(lat));
   dcc_pin_model u_pins (.pin_oe(oe), .pull_low(pull_low), .pin_level(lvl));
   task automatic check(input string name, input logic [16:0] e, input logic [16:0] g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask : check
   task automatic report_and_stop;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [16:0] e);
      if (!w) exp_q.push_back(e);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {16'h0, d}};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      do @(posedge clk_sys); while (rsp.pready !== 1'b1);
      req <= '0;
      @(posedge clk_sys);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, d, 17'h0);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      apb(1'b0, a, 16'h0, {1'b0, e});
   endtask : rd
   // read results leave the queue in order
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc > 3000) begin
         error_cnt++;
         report_and_stop();
      end
      if (rsp.pready === 1'b1 && req.pwrite === 1'b0) check("read", exp_q.pop_front(), {rsp.pslverr, rsp.prdata[15:0]});
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rd(CMD_OFS, 16'h033C);
      for (int i = 0; i < 4; i++) begin
         val[i] = 16'($random(seed));
         wr(CHAN_OFS + 8'(4 * i), val[i]);
         rd(CHAN_OFS + 8'(4 * i), val[i]);
      end
      wr(CMD_OFS, 16'h833C);
      rd(CHAN_OFS, 16'h0000);
      wr(CMD_OFS, 16'hC33C);
      rd(CMD_OFS, 16'h833C);
      for (int i = 0; i < 4; i++) rd(CHAN_OFS + 8'(4 * i), val[i]);
      val[1] = 16'($random(seed));
      wr(CHAN_OFS + 8'h04, val[1]);
      load_n <= 1'b0;
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < 4; i++) rd(CHAN_OFS + 8'(4 * i), val[i]);
      wr(CHAN_OFS + 8'h08, 16'h5A5A);
      wr(CMD_OFS, 16'hC33C);
      repeat (3) @(posedge clk_sys);
      rd(CHAN_OFS + 8'h08, val[2]);
      load_n <= 1'b1;
      wr(CMD_OFS, 16'h9F7C);
      check("power_down", 17'h3, {15'h0, pd_a, pd_b});
      rd(CMD_OFS, 16'h9B3C);
      wr(CMD_OFS, 16'h033C);
      check("power_down", 17'h0, {15'h0, pd_a, pd_b});
      for (int i = 0; i < 3; i++) begin
         pull_low <= 2'(i == 2);
         wr(CMD_OFS, 16'h003C | 16'(i + 1) << 8);
         repeat (3) @(posedge clk_sys);
         rd(CMD_OFS, 16'h003C | 16'(i == 0 ? 1 : 2) << 8);
      end
      pull_low <= 2'h0;
      wr(CMD_OFS, 16'hB33C);
      repeat (6) @(posedge clk_sys);
      rd(CMD_OFS, 16'h033C);
      rd(CHAN_OFS, 16'h0000);
      check("latch", 17'h0, {1'b0, lat[1]});
      apb(1'b0, 8'h04, 16'h0, 17'h10000);
      report_and_stop();
   end
endmodule : dac_command_control_upper_test
`default_nettype wire
